// File: design/isr_error_class.sv
// Error code classifier mapping a logged code onto standard event bits
`timescale 1ns/100ps
module isr_error_class
   import isr_pkg::*;
(
   input wire logic signed [15:0] errCode,
   input wire logic errValid,
   output logic [7:0] errBits
);
   // In-range test used for each negative band
   function automatic logic inBand(input logic signed [15:0] c,
                                   input logic signed [15:0] lo,
                                   input logic signed [15:0] hi);
      inBand = (c >= lo) && (c <= hi);
   endfunction : inBand

   // Classify a logged code into one event bit
   always_comb
   begin
      errBits = 8'h00;
      if (errValid)
      begin
         errBits[BIT_QUERY_ERR] = inBand(errCode, ERR_QUERY_LO, ERR_QUERY_HI); // see RULE3
         errBits[BIT_DEVICE_ERR] = inBand(errCode, ERR_DEV_LO, ERR_DEV_HI)
            || (errCode >= ERR_POS_LO); // see RULE4
         errBits[BIT_EXEC_ERR] = inBand(errCode, ERR_EXEC_LO, ERR_EXEC_HI); // see RULE5
         errBits[BIT_CMD_ERR] = inBand(errCode, ERR_CMD_LO, ERR_CMD_HI); // see RULE6
      end
   end
endmodule : isr_error_class

// File: design/isr_pkg.sv
// Constants and types shared by the instrument status reporting block
// How it works
// RULE1 - Op-done command sets bit 0 when idle
// RULE2 - Event bit 1 always reads zero
// RULE3 - Errors -499..-400 set bit 2
// RULE4 - Errors -399..-300 or 1..32767 set bit 3
// RULE5 - Errors -299..-200 set bit 4
// RULE6 - Errors -199..-100 set bit 5
// RULE7 - Local key sets bit 6, even locked out
// RULE8 - Power cycle sets bit 7
// RULE9 - Query returns event bits as binary sum
// RULE10 - Summary bit 5 from enabled standard events
// RULE11 - Live bits 0,1,3: calibrate, settle, sweep
// RULE12 - Live bits 4,5: error test, trigger wait
// RULE13 - Live bits 9,11: zero cal, pre-sweep calc
// RULE14 - Live bit 10 follows baseband summary
// RULE15 - Live bits 2,6-8,12-15 read zero
// RULE16 - Live register read-only, tracks inputs
// RULE17 - Filtered edges set operation event bits
// RULE18 - Operation events latch, clear on read
// RULE19 - Summary bit 7 from enabled operation events
// RULE20 - Host writes masks as one value
// RULE21 - Standard events hold until read or clear
// RULE22 - Summary is OR of event AND enable
// RULE23 - Mask queries return last written value
// RULE24 - New event wins over clearing read
package isr_pkg;
   // Register selectors for the command port
   localparam logic [2:0] SEL_STD_FLAGS = 3'h0;
   localparam logic [2:0] SEL_STD_MASK = 3'h1;
   localparam logic [2:0] SEL_OP_LIVE = 3'h2;
   localparam logic [2:0] SEL_OP_FALL = 3'h3;
   localparam logic [2:0] SEL_OP_RISE = 3'h4;
   localparam logic [2:0] SEL_OP_EVENTS = 3'h5;
   localparam logic [2:0] SEL_OP_MASK = 3'h6;
   // Standard event bit positions
   localparam int BIT_OP_DONE = 0;
   localparam int BIT_REQ_CTRL = 1;
   localparam int BIT_QUERY_ERR = 2;
   localparam int BIT_DEVICE_ERR = 3;
   localparam int BIT_EXEC_ERR = 4;
   localparam int BIT_CMD_ERR = 5;
   localparam int BIT_LOCAL_KEY = 6;
   localparam int BIT_POWER_ON = 7;
   // Operation live-state bit positions
   localparam int OP_IQ_CAL = 0;
   localparam int OP_SETTLING = 1;
   localparam int OP_SWEEPING = 3;
   localparam int OP_MEASURING = 4;
   localparam int OP_WAIT_TRIG = 5;
   localparam int OP_ZERO_CAL = 9;
   localparam int OP_BASEBAND = 10;
   localparam int OP_SWEEP_CALC = 11;
   // Reset values
   localparam logic [7:0] STD_FLAGS_RST = 8'h80;
   localparam logic [7:0] STD_MASK_RST = 8'h00;
   localparam logic [15:0] OP_MASK_RST = 16'h0000;
   localparam logic [15:0] OP_RISE_RST = 16'h7fff;
   localparam logic [15:0] OP_FALL_RST = 16'h0000;
   // Error code range limits
   localparam logic signed [15:0] ERR_QUERY_LO = 16'shfe0d; // Minus 499
   localparam logic signed [15:0] ERR_QUERY_HI = 16'shfe70; // Minus 400
   localparam logic signed [15:0] ERR_DEV_LO = 16'shfe71; // Minus 399
   localparam logic signed [15:0] ERR_DEV_HI = 16'shfed4; // Minus 300
   localparam logic signed [15:0] ERR_EXEC_LO = 16'shfed5; // Minus 299
   localparam logic signed [15:0] ERR_EXEC_HI = 16'shff38; // Minus 200
   localparam logic signed [15:0] ERR_CMD_LO = 16'shff39; // Minus 199
   localparam logic signed [15:0] ERR_CMD_HI = 16'shff9c; // Minus 100
   localparam logic signed [15:0] ERR_POS_LO = 16'sh0001; // Lowest positive code
   // Op-done tracking states
   typedef enum logic [0:0] {OPC_IDLE, OPC_ARMED} isr_opc_type;
endpackage : isr_pkg

// File: design/isr_status_regs.sv
// Standard event and operation status register groups with summary bits
`timescale 1ns/100ps
module isr_status_regs
   import isr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic srst,
   // Host command port
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [2:0] cmdSel,
   input wire logic [15:0] cmdWdata,
   input wire logic clearStatusCmd,
   input wire logic opDoneCmd,
   output logic [15:0] readData,
   output logic readValid,
   // Device events
   input wire logic opsPending,
   input wire logic errLogged,
   input wire logic signed [15:0] errCode,
   input wire logic localKeyPin,
   input wire logic powerCycled,
   // Live status inputs
   input wire logic iqCalBusy,
   input wire logic settlingBusy,
   input wire logic sweepBusy,
   input wire logic bitErrTestBusy,
   input wire logic waitTrigger,
   input wire logic dcModulationZeroCal,
   input wire logic basebandSummary,
   input wire logic sweepCalcBusy,
   // Summary outputs to the status byte
   output logic stdSummary,
   output logic opSummary
);
   import isr_pkg::*;

   // All state of the block
   typedef struct packed {
      logic [1:0] keySync;       // Two-stage synchroniser of the local key pin
      logic keyPrev;             // Previous synchronised key level
      logic [7:0] stdFlags;      // Latched standard events
      logic [7:0] stdMask;       // Standard event enable mask
      logic [15:0] opLive;       // Registered live condition
      logic [15:0] opFall;       // Falling-edge filter
      logic [15:0] opRise;       // Rising-edge filter
      logic [15:0] opEvents;     // Latched operation events
      logic [15:0] opMask;       // Operation enable mask
      isr_opc_type opcState;     // Op-done tracking
      logic [15:0] rdData;       // Read answer
      logic rdValid;             // Read answer strobe
      logic stdSum;              // Summary bit 5
      logic opSum;               // Summary bit 7
   } isr_state_type;

   isr_state_type state_reg;
   isr_state_type state_next;
   logic [7:0] errBits;          // Error class bits for this cycle
   logic [15:0] liveNow;         // Live condition assembled from inputs
   logic [7:0] stdSet;           // Standard events arriving this cycle
   logic [15:0] opSet;           // Operation events arriving this cycle
   logic [7:0] stdAfter;         // Standard flags after set and clear
   logic [15:0] opAfter;         // Operation events after set and clear
   logic keyPress;               // Synchronised rising edge of the key

   // Error code classifier
   isr_error_class u_err
   (
      .errCode(errCode),
      .errValid(errLogged),
      .errBits(errBits)
   );

   // Any enabled event drives a summary bit
   function automatic logic summaryOf(input logic [15:0] ev, input logic [15:0] en);
      summaryOf = |(ev & en); // see RULE22
   endfunction : summaryOf

   // Assemble live condition; unused bits stay zero
   always_comb
   begin
      liveNow = 16'h0000; // see RULE15
      liveNow[OP_IQ_CAL] = iqCalBusy; // see RULE11
      liveNow[OP_SETTLING] = settlingBusy; // see RULE11
      liveNow[OP_SWEEPING] = sweepBusy; // see RULE11
      liveNow[OP_MEASURING] = bitErrTestBusy; // see RULE12
      liveNow[OP_WAIT_TRIG] = waitTrigger; // see RULE12
      liveNow[OP_ZERO_CAL] = dcModulationZeroCal; // see RULE13
      liveNow[OP_BASEBAND] = basebandSummary; // see RULE14
      liveNow[OP_SWEEP_CALC] = sweepCalcBusy; // see RULE13
   end

   // Next-state logic
   always_comb
   begin
      state_next = state_reg;
      keyPress = state_reg.keySync[1] && !state_reg.keyPrev;
      state_next.keySync = {state_reg.keySync[0], localKeyPin};
      state_next.keyPrev = state_reg.keySync[1];
      // Standard events arriving now
      stdSet = errBits;
      stdSet[BIT_LOCAL_KEY] = keyPress; // see RULE7
      stdSet[BIT_POWER_ON] = powerCycled; // see RULE8
      stdSet[BIT_OP_DONE] = 1'b0;
      // Op-done waits for pending operations to drain
      case (state_reg.opcState)
         OPC_IDLE:
         begin
            if (opDoneCmd)
            begin
               if (!opsPending)
               begin
                  stdSet[BIT_OP_DONE] = 1'b1; // see RULE1
               end
               else
               begin
                  state_next.opcState = OPC_ARMED;
               end
            end
         end
         OPC_ARMED:
         begin
            if (!opsPending)
            begin
               stdSet[BIT_OP_DONE] = 1'b1; // see RULE1
               state_next.opcState = OPC_IDLE;
            end
         end
         default:
         begin
            state_next.opcState = OPC_IDLE;
         end
      endcase
      if (clearStatusCmd)
      begin
         state_next.opcState = OPC_IDLE;
      end
      // Filtered transitions of live condition
      opSet = (liveNow & ~state_reg.opLive & state_reg.opRise)
            | (~liveNow & state_reg.opLive & state_reg.opFall); // see RULE17
      state_next.opLive = liveNow; // see RULE16
      // Clear on read or clear-status, then set wins
      stdAfter = state_reg.stdFlags;
      if (clearStatusCmd || (cmdRead && cmdSel == SEL_STD_FLAGS))
      begin
         stdAfter = 8'h00; // see RULE21
      end
      stdAfter = stdAfter | stdSet; // see RULE24
      stdAfter[BIT_REQ_CTRL] = 1'b0; // see RULE2
      state_next.stdFlags = stdAfter;
      opAfter = state_reg.opEvents;
      if (clearStatusCmd || (cmdRead && cmdSel == SEL_OP_EVENTS))
      begin
         opAfter = 16'h0000; // see RULE18
      end
      opAfter = opAfter | opSet; // see RULE24
      state_next.opEvents = opAfter; // see RULE18
      // Mask writes; live and event registers ignore writes
      if (cmdWrite)
      begin
         case (cmdSel)
            SEL_STD_MASK: state_next.stdMask = cmdWdata[7:0]; // see RULE23
            SEL_OP_FALL: state_next.opFall = cmdWdata; // see RULE23
            SEL_OP_RISE: state_next.opRise = cmdWdata; // see RULE23
            SEL_OP_MASK: state_next.opMask = cmdWdata; // see RULE23
            default: state_next.opMask = state_reg.opMask;
         endcase
      end
      // Read answer, one cycle after the request
      state_next.rdValid = cmdRead;
      state_next.rdData = state_reg.rdData;
      if (cmdRead)
      begin
         case (cmdSel)
            SEL_STD_FLAGS: state_next.rdData = {8'h00, state_reg.stdFlags}; // see RULE9
            SEL_STD_MASK: state_next.rdData = {8'h00, state_reg.stdMask};
            SEL_OP_LIVE: state_next.rdData = state_reg.opLive; // see RULE16
            SEL_OP_FALL: state_next.rdData = state_reg.opFall;
            SEL_OP_RISE: state_next.rdData = state_reg.opRise;
            SEL_OP_EVENTS: state_next.rdData = state_reg.opEvents;
            SEL_OP_MASK: state_next.rdData = state_reg.opMask;
            default: state_next.rdData = 16'h0000;
         endcase
      end
      // Summaries from the latched events and masks
      state_next.stdSum = summaryOf({8'h00, stdAfter}, {8'h00, state_next.stdMask}); // see RULE10
      state_next.opSum = summaryOf(opAfter, state_next.opMask); // see RULE19
   end

   // State register
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_reg <= '{keySync: 2'b00, keyPrev: 1'b0, stdFlags: STD_FLAGS_RST,
                        stdMask: STD_MASK_RST, opLive: 16'h0000, opFall: OP_FALL_RST,
                        opRise: OP_RISE_RST, opEvents: 16'h0000, opMask: OP_MASK_RST,
                        opcState: OPC_IDLE, rdData: 16'h0000, rdValid: 1'b0,
                        stdSum: 1'b0, opSum: 1'b0};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign readData = state_reg.rdData;
   assign readValid = state_reg.rdValid;
   assign stdSummary = state_reg.stdSum;
   assign opSummary = state_reg.opSum;

   // Request-control bit never seen set
   chk_req_ctrl_zero: assert property (@(posedge clk_sys) disable iff (srst) // see RULE2
      !state_reg.stdFlags[BIT_REQ_CTRL])
      else $error("request control bit set");
   // Query error sets bit 2 next cycle
   chk_query_err: assert property (@(posedge clk_sys) disable iff (srst) // see RULE3
      errLogged && errCode == 16'shfe3e |=> state_reg.stdFlags[BIT_QUERY_ERR])
      else $error("query error not flagged");
   // Positive code sets device error bit
   chk_device_err: assert property (@(posedge clk_sys) disable iff (srst) // see RULE4
      errLogged && errCode == 16'sh0001 |=> state_reg.stdFlags[BIT_DEVICE_ERR])
      else $error("device error not flagged");
   // Op-done with nothing pending flags bit 0
   chk_op_done: assert property (@(posedge clk_sys) disable iff (srst) // see RULE1
      opDoneCmd && !opsPending && state_reg.opcState == OPC_IDLE
      |=> state_reg.stdFlags[BIT_OP_DONE])
      else $error("op done not flagged");
   // Power cycle flags bit 7
   chk_power_on: assert property (@(posedge clk_sys) disable iff (srst) // see RULE8
      powerCycled |=> state_reg.stdFlags[BIT_POWER_ON])
      else $error("power on not flagged");
   // Live register follows inputs one cycle late
   chk_live_track: assert property (@(posedge clk_sys) disable iff (srst) // see RULE16
      ##1 state_reg.opLive == $past(liveNow))
      else $error("live register stale");
   // Unused live bits stay zero
   chk_live_zero: assert property (@(posedge clk_sys) disable iff (srst) // see RULE15
      (state_reg.opLive & 16'hf1c4) == 16'h0000)
      else $error("unused live bit set");
   // Enabled rising edge latches an event
   sequence seqRise;
      !state_reg.opLive[OP_SWEEPING] && sweepBusy && state_reg.opRise[OP_SWEEPING];
   endsequence
   chk_rise_event: assert property (@(posedge clk_sys) disable iff (srst) // see RULE17
      seqRise |=> state_reg.opEvents[OP_SWEEPING])
      else $error("rising edge not latched");
   // Event bit stays until a clearing read
   chk_event_hold: assert property (@(posedge clk_sys) disable iff (srst) // see RULE18
      state_reg.opEvents[OP_SWEEPING] && !clearStatusCmd
      && !(cmdRead && cmdSel == SEL_OP_EVENTS) |=> state_reg.opEvents[OP_SWEEPING])
      else $error("operation event lost");
   // Summary bits follow event and mask
   chk_summary: assert property (@(posedge clk_sys) disable iff (srst) // see RULE19
      ##1 opSummary == |(state_reg.opEvents & state_reg.opMask)
      && stdSummary == |(state_reg.stdFlags & state_reg.stdMask))
      else $error("summary mismatch");
   // Read returns flags one cycle later
   chk_read_answer: assert property (@(posedge clk_sys) disable iff (srst) // see RULE9
      cmdRead && cmdSel == SEL_STD_FLAGS
      |=> readValid && readData == {8'h00, $past(state_reg.stdFlags)})
      else $error("flag read wrong");
endmodule : isr_status_regs

// File: tb/isr_host_model.sv
// Host controller model driving the status command port
`timescale 1ns/100ps
module isr_host_model
(
   input wire logic clk_sys,
   output logic cmdWrite,
   output logic cmdRead,
   output logic [2:0] cmdSel,
   output logic [15:0] cmdWdata,
   output logic clearStatusCmd,
   output logic opDoneCmd
);
   // Idle port values at time zero
   initial
   begin
      {cmdWrite, cmdRead, clearStatusCmd, opDoneCmd} = 4'h0;
      cmdSel = 3'h7;
      cmdWdata = 16'h5a5a;
   end
   // One access held for one edge; released select and data are scrambled, not kept
   task automatic access(input logic wr, input logic [2:0] sel, input logic [15:0] data);
      @(posedge clk_sys);
      #1;
      cmdWrite = wr;
      cmdRead = !wr;
      cmdSel = sel;
      cmdWdata = data; // A mask goes as one summed value
      @(posedge clk_sys);
      #1;
      {cmdWrite, cmdRead} = 2'h0;
      cmdSel = ~sel;
      cmdWdata = ~data;
   endtask : access
   // One-cycle command pulse: 1 clears status, 0 asks for op-done
   task automatic pulse(input logic clr);
      @(posedge clk_sys);
      #1;
      clearStatusCmd = clr;
      opDoneCmd = !clr;
      @(posedge clk_sys);
      #1;
      {clearStatusCmd, opDoneCmd} = 2'h0;
   endtask : pulse
endmodule : isr_host_model

// File: tb/test_instrument_status_reporting.sv
// Self-checking bench for the status register block
`timescale 1ns/100ps
module test_instrument_status_reporting;
   import isr_pkg::*;
   logic clk_sys, srst, cmdWrite, cmdRead, clearStatusCmd, opDoneCmd, readValid;
   logic [2:0] cmdSel;
   logic [15:0] cmdWdata, readData, rnd;
   logic signed [15:0] errCode;
   logic errLogged, opsPending, localKeyPin, powerCycled, stdSummary, opSummary;
   logic [7:0] liveIn; // sweepCalc baseband zeroCal trigger bert sweep settle iqCal
   logic [18:0] expQ[$]; // Expected read answers: select over value
   logic [18:0] head; // Oldest note
   int errors = 0;
   int samples_checked = 0;
   int codes[14] = '{-500, -499, -400, -399, -300, -299, -200, -199, -100, -99, 0, 1,
      32767, -32768};
   logic [7:0] codeBits[14] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h10, 8'h10, 8'h20,
      8'h20, 8'h00, 8'h00, 8'h08, 8'h08, 8'h00};
   logic [2:0] maskSel[4] = '{SEL_STD_MASK, SEL_OP_FALL, SEL_OP_RISE, SEL_OP_MASK};
   isr_status_regs i_isr_status_regs (.clk_sys(clk_sys), .srst(srst), .cmdWrite(cmdWrite),
      .cmdRead(cmdRead), .cmdSel(cmdSel), .cmdWdata(cmdWdata), .readData(readData),
      .clearStatusCmd(clearStatusCmd), .opDoneCmd(opDoneCmd), .readValid(readValid),
      .opsPending(opsPending), .errLogged(errLogged), .errCode(errCode),
      .localKeyPin(localKeyPin), .powerCycled(powerCycled), .iqCalBusy(liveIn[0]),
      .settlingBusy(liveIn[1]), .sweepBusy(liveIn[2]), .bitErrTestBusy(liveIn[3]),
      .waitTrigger(liveIn[4]), .dcModulationZeroCal(liveIn[5]),
      .basebandSummary(liveIn[6]), .sweepCalcBusy(liveIn[7]),
      .stdSummary(stdSummary), .opSummary(opSummary));
   isr_host_model i_isr_host_model (.clk_sys(clk_sys), .cmdWrite(cmdWrite),
      .cmdRead(cmdRead), .cmdSel(cmdSel), .cmdWdata(cmdWdata),
      .clearStatusCmd(clearStatusCmd), .opDoneCmd(opDoneCmd));
   // Free-running system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Pseudo-random source
   function automatic logic [15:0] xorshift(input logic [15:0] s);
      logic [15:0] x;
      x = s ^ (s << 7);
      x = x ^ (x >> 9);
      return x ^ (x << 8);
   endfunction : xorshift
   // Where each live input lands in the live register
   function automatic logic [15:0] liveMap(input logic [7:0] l);
      return {4'h0, l[7], l[6], l[5], 3'h0, l[4], l[3], l[2], 1'b0, l[1], l[0]};
   endfunction : liveMap
   task automatic compare(input string name, input logic [15:0] expv, input logic [15:0] seen);
      samples_checked++;
      if (seen !== expv)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, expv, seen);
      end
   endtask : compare
   // Notes the expected answer, then issues the read
   task automatic hostRead(input logic [2:0] sel, input logic [15:0] expv);
      expQ.push_back({sel, expv});
      i_isr_host_model.access(1'b0, sel, 16'h0000);
   endtask : hostRead
   task automatic hostWrite(input logic [2:0] sel, input logic [15:0] data);
      i_isr_host_model.access(1'b1, sel, data);
   endtask : hostWrite
   // Waits n edges and steps just past the last
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : idle
   // One-cycle error report; the code is scrambled once invalid
   task automatic pulseErr(input int code);
      idle(1);
      errLogged = 1'b1;
      errCode = code[15:0];
      idle(1);
      errLogged = 1'b0;
      errCode = ~errCode;
   endtask : pulseErr
   task automatic results;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   // Read answers are matched against the oldest note, mid-cycle where they are settled
   always @(negedge clk_sys)
   begin
      if (readValid === 1'b1)
      begin
         head = (expQ.size() > 0) ? expQ.pop_front() : 19'h7ffff;
         compare("readData", head[15:0], readData);
      end
   end
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      results();
   end
   // Main sequence
   initial
   begin
      {srst, errLogged, opsPending, localKeyPin, powerCycled} = 5'h10;
      errCode = 16'sh0000;
      liveIn = 8'h00;
      rnd = 16'h0030;
      repeat (3) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      hostRead(SEL_STD_FLAGS, 16'h0080);
      hostRead(SEL_STD_FLAGS, 16'h0000);
      hostRead(SEL_OP_RISE, 16'h7fff);
      hostRead(SEL_OP_FALL, 16'h0000);
      hostRead(3'h7, 16'h0000);
      // Both ends of every error range, and codes just outside
      for (int i = 0; i < 14; i++)
      begin
         pulseErr(codes[i]);
         hostRead(SEL_STD_FLAGS, {8'h00, codeBits[i]});
      end
      powerCycled = 1'b1;
      localKeyPin = 1'b1;
      idle(1);
      powerCycled = 1'b0;
      idle(6);
      hostRead(SEL_STD_FLAGS, 16'h00c0);
      // Op-done waits for pending work
      opsPending = 1'b1;
      i_isr_host_model.pulse(1'b0);
      idle(3);
      hostRead(SEL_STD_FLAGS, 16'h0000);
      opsPending = 1'b0;
      idle(3);
      hostRead(SEL_STD_FLAGS, 16'h0001);
      // Op-done with nothing pending flags at once
      i_isr_host_model.pulse(1'b0);
      hostRead(SEL_STD_FLAGS, 16'h0001);
      hostWrite(SEL_STD_MASK, 16'h0004);
      pulseErr(-450);
      idle(2);
      compare("stdSummary", 16'h0001, {15'h0, stdSummary});
      hostRead(SEL_STD_FLAGS, 16'h0004);
      idle(2);
      compare("stdSummary", 16'h0000, {15'h0, stdSummary});
      pulseErr(-150);
      i_isr_host_model.pulse(1'b1);
      hostWrite(SEL_STD_FLAGS, 16'h00ff);
      hostRead(SEL_STD_FLAGS, 16'h0000);
      // Event and clearing read on the same edge
      fork
         pulseErr(-450);
         hostRead(SEL_STD_FLAGS, 16'h0000);
      join
      hostRead(SEL_STD_FLAGS, 16'h0004);
      // Filtered edges into the operation events
      hostWrite(SEL_OP_RISE, 16'h0008);
      hostWrite(SEL_OP_FALL, 16'h0200);
      hostWrite(SEL_OP_MASK, 16'h0008);
      liveIn = 8'h24;
      idle(3);
      compare("opSummary", 16'h0001, {15'h0, opSummary});
      hostRead(SEL_OP_LIVE, 16'h0208);
      hostRead(SEL_OP_EVENTS, 16'h0008);
      hostRead(SEL_OP_EVENTS, 16'h0000);
      liveIn = 8'h04;
      idle(3);
      compare("opSummary", 16'h0000, {15'h0, opSummary});
      hostRead(SEL_OP_EVENTS, 16'h0200);
      // Clear-status empties the operation events; event writes are refused
      liveIn = 8'h24;
      idle(2);
      liveIn = 8'h04;
      idle(2);
      i_isr_host_model.pulse(1'b1);
      hostWrite(SEL_OP_EVENTS, 16'hffff);
      hostRead(SEL_OP_EVENTS, 16'h0000);
      // Random live states, refused live writes and mask read-back
      for (int i = 0; i < 8; i++)
      begin
         rnd = xorshift(rnd);
         liveIn = rnd[7:0];
         hostWrite(SEL_OP_LIVE, ~rnd);
         hostRead(SEL_OP_LIVE, liveMap(rnd[7:0]));
         hostWrite(maskSel[i % 4], rnd);
         hostRead(maskSel[i % 4], (i % 4 == 0) ? {8'h00, rnd[7:0]} : rnd);
      end
      for (int i = 0; i < 20 && expQ.size() > 0; i++)
         @(posedge clk_sys);
      if (expQ.size() > 0)
         errors++;
      results();
   end
endmodule : test_instrument_status_reporting
